// ### scrx_defs.vh
/*
 header of register offsets, field positions and timing constants for the serial port block.
 assumes inclusion by bare name from the design file.
*/
`ifndef SCRX_DEFS_VH
`define SCRX_DEFS_VH
`define SCRX_OFF_BDH 6'h00
`define SCRX_OFF_BDL 6'h04
`define SCRX_OFF_C1 6'h08
`define SCRX_OFF_C2 6'h0c
`define SCRX_OFF_S1 6'h10
`define SCRX_OFF_S2 6'h14
`define SCRX_OFF_C3 6'h18
`define SCRX_OFF_D 6'h1c
`define SCRX_OFF_EN 6'h20
`define SCRX_RST8 8'h00
`define SCRX_BDH_EDGE 6
`define SCRX_BDH_AUTO 5
`define SCRX_C1_LOOP 7
`define SCRX_C1_STOP2 6
`define SCRX_C1_SWIRE 5
`define SCRX_C1_NINE 4
`define SCRX_C1_WAKE 3
`define SCRX_C1_ILT 2
`define SCRX_C1_PE 1
`define SCRX_C1_PODD 0
`define SCRX_C2_TIE 7
`define SCRX_C2_TCIE 6
`define SCRX_C2_RIE 5
`define SCRX_C2_ILIE 4
`define SCRX_C2_TE 3
`define SCRX_C2_RE 2
`define SCRX_C2_SLEEP 1
`define SCRX_S2_IDLESEL 3
`define SCRX_S2_INV 4
`define SCRX_C3_DIR 5
`define SCRX_SLOT_LAST 4'hf
`define SCRX_SYNC_ONES 2'h3
`define SCRX_IDLE_BASE 4'ha
`define SCRX_AUTO_CHAR 8'h55
`define SCRX_AUTO_EDGES 4'h5
`endif

// ### scrx_uart.v
/*
 serial port with oversampled receiver, sleep/wakeup, pin modes, auto-baud and an axi4-lite slave.
 assumes a single 100 MHz clock; serial pins synchronous to aclk.
*/
// Decided for this implementation: register access over AXI4-Lite.
// Function
// - sample rx at sixteen per bit; edge is zero after three ones
// - vote slots three, five, seven; two zeros start reception else rearm
// - every bit level after the start bit is majority of slots eight, nine, ten
// - qualified start bit counts as zero whatever slots eight to ten say
// - noise flag on store if any checked sample disagrees with its bit
// - falling edges during reception realign the slot counter
// - sleep suppresses receive flags except idle when idle-select set
// - wake select: zero idle line, one address mark; hardware clears sleep
// - idle wakeup clears sleep; flags resume with next character
// - address mark msb one clears sleep and that character sets flags
// - loop mode routes tx to rx internally; receiver ignores rx pin, edge wake request still follows it
// - single wire: direction bit zero tx pin input, one output
// - enabled edge interrupt detects rx pin low asynchronously as wake request while rx inversion is clear
// - 13-bit divisor; zero stops baud, else clock over sixteen times divisor
// - auto-baud measures next 0x55 once per enable then updates divisor
// - stop width bit selects one or two stop bits on transmit; receiver checks one
// - width bit selects nine or eight bit characters
// - idle count after stop or after start needing ten plus extras
// - parity generated and checked over seven or eight data bits
// - parity type odd when one, even when zero, over whole character
// - interrupt enables gate outputs only, except edge enable also gates edge flag setting
// - transmitter enable off then on queues one idle character
// - any divisor write clears the baud counter
`timescale 1ns/10ps
`include "scrx_defs.vh"
`default_nettype none
module scrx_uart (
    input wire aclk,
    input wire aresetn,
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire rx_pin,
    input wire tx_pin_in,
    output wire tx_pin_out,
    output wire tx_pin_oe,
    output wire irq,
    output wire rx_wake_irq
);
    localparam RS_IDLE = 2'd0;
    localparam RS_QUAL = 2'd1;
    localparam RS_DATA = 2'd2;

    reg [7:0] bdh, bdl, c1, c2, s2c, c3c, men;
    reg [7:0] rx_data;
    reg rx_bit8;
    reg f_tdre, f_tc, f_rdrf, f_idle, f_or, f_nf, f_fe, f_pf;
    reg f_edge;

    // axi write channel: address and data latched independently
    reg aw_held, w_held;
    reg [5:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire wr_ok = wr_go && w_strb[0] && (aw_addr[1:0] == 2'b00) && (aw_addr <= `SCRX_OFF_EN);
    wire rd_go = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;
    wire rd_data_reg = rd_go && (s_axi_araddr == `SCRX_OFF_D);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 6'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= ((aw_addr[1:0] == 2'b00) && (aw_addr <= `SCRX_OFF_EN)) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire wr_bd = wr_ok && (aw_addr == `SCRX_OFF_BDH || aw_addr == `SCRX_OFF_BDL);
    wire wr_c2 = wr_ok && (aw_addr == `SCRX_OFF_C2);
    wire wr_d = wr_ok && (aw_addr == `SCRX_OFF_D);

    // baud tick at sixteen times the bit rate
    reg [12:0] baud_cnt;
    wire [12:0] divisor = {bdh[4:0], bdl};
    wire tick = (divisor != 13'h0000) && (baud_cnt == divisor - 13'h0001);
    always @(posedge aclk) begin
        if (!aresetn || wr_bd || tick || divisor == 13'h0000) begin
            baud_cnt <= 13'h0000;
        end else begin
            baud_cnt <= baud_cnt + 13'h0001;
        end
    end

    // transmitter: shifts a frame or an idle character on each sixteenth tick
    reg [11:0] tx_shift;
    reg [3:0] tx_bits, tx_sub;
    reg tx_busy, tx_pend, idle_pend, tx_line;
    reg [7:0] tx_buf;
    wire par_odd = c1[`SCRX_C1_PODD];
    function parity_of;
        input [7:0] d;
        input nine;
        input odd;
        begin
            parity_of = (nine ? ^d : ^d[6:0]) ^ odd;
        end
    endfunction
    wire [3:0] frame_len = 4'd10 + {3'd0, c1[`SCRX_C1_STOP2]} + {3'd0, c1[`SCRX_C1_NINE]};
    wire [7:0] tx_byte = (c1[`SCRX_C1_PE] && !c1[`SCRX_C1_NINE]) ?
        {parity_of(tx_buf, 1'b0, par_odd), tx_buf[6:0]} : tx_buf;
    wire tx_b9 = c1[`SCRX_C1_PE] ? parity_of(tx_buf, 1'b1, par_odd) : 1'b1;
    wire te_rise = wr_c2 && w_data[`SCRX_C2_TE] && !c2[`SCRX_C2_TE];
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_shift <= 12'hfff;
            tx_bits <= 4'h0;
            tx_sub <= 4'h0;
            tx_busy <= 1'b0;
            tx_pend <= 1'b0;
            idle_pend <= 1'b0;
            tx_line <= 1'b1;
            tx_buf <= `SCRX_RST8;
            f_tdre <= 1'b0;
            f_tc <= 1'b0;
        end else begin
            if (te_rise) begin
                idle_pend <= 1'b1;
                f_tdre <= 1'b1;
                f_tc <= 1'b0;
            end
            if (wr_d) begin
                tx_buf <= w_data[7:0];
                tx_pend <= 1'b1;
                f_tdre <= 1'b0;
                f_tc <= 1'b0;
            end
            if (!tx_busy && c2[`SCRX_C2_TE] && (idle_pend || tx_pend)) begin
                tx_busy <= 1'b1;
                tx_sub <= 4'h0;
                tx_bits <= frame_len;
                if (idle_pend) begin
                    idle_pend <= 1'b0;
                    tx_shift <= 12'hfff;
                end else begin
                    tx_pend <= 1'b0;
                    f_tdre <= !wr_d;
                    tx_shift <= c1[`SCRX_C1_NINE] ? {2'b11, tx_b9, tx_byte, 1'b0} : {3'b111, tx_byte, 1'b0};
                end
            end else if (tx_busy && tick) begin
                tx_sub <= tx_sub + 4'h1;
                if (tx_sub == 4'h0) begin
                    tx_line <= tx_shift[0];
                    tx_shift <= {1'b1, tx_shift[11:1]};
                end
                if (tx_sub == `SCRX_SLOT_LAST) begin
                    tx_bits <= tx_bits - 4'h1;
                    if (tx_bits == 4'h1) begin
                        tx_busy <= 1'b0;
                        if (!tx_pend && !idle_pend && !wr_d) begin
                            f_tc <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // pin routing
    wire loop_on = c1[`SCRX_C1_LOOP];
    wire swire = loop_on && c1[`SCRX_C1_SWIRE];
    assign tx_pin_oe = !swire || c3c[`SCRX_C3_DIR];
    assign tx_pin_out = tx_line;
    wire raw_in = !loop_on ? rx_pin : (swire ? tx_pin_in : tx_line);
    wire rx_in = raw_in ^ s2c[`SCRX_S2_INV];

    // receiver sampling state
    reg [1:0] rs;
    reg [2:0] hist;
    reg [3:0] slot, rbit, nbits;
    reg [2:0] qv, mv;
    reg noisy;
    reg [3:0] idle_cnt;
    reg idle_arm;
    reg sleep;
    reg ab_done, ab_run;
    reg [19:0] ab_cnt;
    reg [3:0] ab_edges;
    wire fall = (hist == 3'b111) && !rx_in;
    wire maj = (mv[0] & mv[1]) | (mv[0] & mv[2]) | (mv[1] & mv[2]);
    wire [2:0] mv_now = {rx_in, mv[2:1]};
    wire maj_now = (mv_now[0] & mv_now[1]) | (mv_now[0] & mv_now[2]) | (mv_now[1] & mv_now[2]);
    wire [3:0] rx_total = 4'd10 + {3'd0, c1[`SCRX_C1_NINE]};
    wire [3:0] idle_need = `SCRX_IDLE_BASE + {3'd0, c1[`SCRX_C1_STOP2]} + {3'd0, c1[`SCRX_C1_NINE]};
    reg store_now;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rs <= RS_IDLE;
            hist <= 3'b000;
            slot <= 4'h0;
            rbit <= 4'h0;
            nbits <= 4'h0;
            qv <= 3'b000;
            mv <= 3'b000;
            noisy <= 1'b0;
            store_now <= 1'b0;
        end else begin
            store_now <= 1'b0;
            if (tick) begin
                hist <= {hist[1:0], rx_in};
                slot <= slot + 4'h1;
                case (rs)
                    RS_IDLE: begin
                        if (fall && c2[`SCRX_C2_RE]) begin
                            rs <= RS_QUAL;
                            slot <= 4'h2;
                            noisy <= 1'b0;
                        end
                    end
                    RS_QUAL: begin
                        if (slot == 4'h3 || slot == 4'h5 || slot == 4'h7) begin
                            qv <= {rx_in, qv[2:1]};
                            noisy <= noisy | rx_in;
                        end else if (slot > 4'h3 && slot < 4'h8) begin
                            noisy <= noisy | rx_in;
                        end
                        if (slot == 4'h8) begin
                            if ((qv[0] + qv[1] + qv[2]) >= 2'd2) begin
                                rs <= RS_IDLE;
                            end else begin
                                rs <= RS_DATA;
                                rbit <= 4'h0;
                                nbits <= rx_total;
                                mv <= {rx_in, 2'b00};
                                noisy <= noisy | rx_in;
                            end
                        end
                    end
                    RS_DATA: begin
                        if (fall) begin
                            slot <= 4'h2;
                        end
                        if (slot >= 4'h8 && slot <= 4'ha) begin
                            mv <= mv_now;
                        end
                        if (slot == 4'ha) begin
                            if (rbit == 4'h0) begin
                                noisy <= noisy | (mv_now != 3'b000);
                            end else begin
                                noisy <= noisy | (mv_now != 3'b000 && mv_now != 3'b111);
                            end
                            rbit <= rbit + 4'h1;
                            if (rbit == nbits - 4'h1) begin
                                rs <= RS_IDLE;
                                store_now <= 1'b1;
                            end
                        end
                    end
                    default: rs <= RS_IDLE;
                endcase
            end
        end
    end
    // indexed bit arrangement: rebuild frame word from serial bits
    reg [10:0] frame;
    always @(posedge aclk) begin
        if (!aresetn) begin
            frame <= 11'h000;
        end else if (tick && rs == RS_DATA && slot == 4'ha) begin
            frame[rbit] <= (rbit == 4'h0) ? 1'b0 : maj_now;
        end
    end
    wire [8:0] fw = frame[9:1];
    wire f_msb = c1[`SCRX_C1_NINE] ? fw[8] : fw[7];
    wire f_stop = c1[`SCRX_C1_NINE] ? frame[10] : frame[9];
    wire f_pbad = c1[`SCRX_C1_PE] && ((c1[`SCRX_C1_NINE] ? ^fw[8:0] : ^fw[7:0]) != par_odd);

    // store, flags, sleep and idle detection
    wire idle_done = idle_arm && tick && slot == `SCRX_SLOT_LAST && idle_cnt == idle_need - 4'h1;
    wire wake_addr = store_now && sleep && c1[`SCRX_C1_WAKE] && f_msb;
    wire flags_ok = !sleep || wake_addr;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_data <= `SCRX_RST8;
            rx_bit8 <= 1'b0;
            {f_rdrf, f_idle, f_or, f_nf, f_fe, f_pf} <= 6'b000000;
            sleep <= 1'b0;
            idle_cnt <= 4'h0;
            idle_arm <= 1'b0;
        end else begin
            if (rd_data_reg) begin
                {f_rdrf, f_idle, f_or, f_nf, f_fe, f_pf} <= 6'b000000;
            end
            if (wr_c2) begin
                sleep <= w_data[`SCRX_C2_SLEEP];
            end
            if (store_now && flags_ok) begin
                if (f_rdrf && !rd_data_reg) begin
                    f_or <= 1'b1;
                end else begin
                    rx_data <= fw[7:0];
                    rx_bit8 <= fw[8];
                    f_rdrf <= 1'b1;
                    f_nf <= noisy;
                    f_fe <= !f_stop;
                    f_pf <= f_pbad;
                end
            end
            if (wake_addr) begin
                sleep <= 1'b0;
            end
            // idle counter restarts on any zero; reference point set by idle type
            if (rs == RS_QUAL || (rs == RS_DATA && !c1[`SCRX_C1_ILT] && rx_in == 1'b0) || !rx_in) begin
                idle_cnt <= 4'h0;
            end else if (tick && slot == `SCRX_SLOT_LAST && idle_arm && (rs == RS_IDLE || !c1[`SCRX_C1_ILT])) begin
                idle_cnt <= idle_cnt + 4'h1;
            end
            if (store_now) begin
                idle_arm <= 1'b1;
            end
            if (idle_done) begin
                idle_arm <= 1'b0;
                if (sleep && !c1[`SCRX_C1_WAKE]) begin
                    sleep <= 1'b0;
                end
                if (!sleep || s2c[`SCRX_S2_IDLESEL]) begin
                    f_idle <= 1'b1;
                end
            end
        end
    end

    // auto-baud: count clocks over the first eight bit times of a 0x55 frame
    reg ab_prev;
    wire ab_arm = bdh[`SCRX_BDH_AUTO] && !ab_done;
    always @(posedge aclk) begin
        if (!aresetn) begin
            ab_done <= 1'b0;
            ab_run <= 1'b0;
            ab_cnt <= 20'h0_0000;
            ab_edges <= 4'h0;
            ab_prev <= 1'b1;
        end else begin
            ab_prev <= rx_in;
            if (!bdh[`SCRX_BDH_AUTO]) begin
                ab_done <= 1'b0;
                ab_run <= 1'b0;
            end else if (ab_arm) begin
                if (ab_prev && !rx_in) begin
                    if (!ab_run) begin
                        ab_run <= 1'b1;
                        ab_cnt <= 20'h0_0000;
                        ab_edges <= 4'h0;
                    end else begin
                        ab_edges <= ab_edges + 4'h1;
                        if (ab_edges == `SCRX_AUTO_EDGES - 4'h2) begin
                            ab_run <= 1'b0;
                            ab_done <= 1'b1;
                        end
                    end
                end else if (ab_run) begin
                    ab_cnt <= ab_cnt + 20'h0_0001;
                end
            end
        end
    end
    // eight bit times over sixteen slots: divisor = clocks / 128
    wire ab_fire = ab_arm && ab_run && ab_prev && !rx_in && ab_edges == `SCRX_AUTO_EDGES - 4'h2;

    // register file
    always @(posedge aclk) begin
        if (!aresetn) begin
            bdh <= `SCRX_RST8;
            bdl <= `SCRX_RST8;
            c1 <= `SCRX_RST8;
            c2 <= `SCRX_RST8;
            s2c <= `SCRX_RST8;
            c3c <= `SCRX_RST8;
            men <= `SCRX_RST8;
            f_edge <= 1'b0;
        end else begin
            if (wr_ok) begin
                case (aw_addr)
                    `SCRX_OFF_BDH: bdh <= w_data[7:0];
                    `SCRX_OFF_BDL: bdl <= w_data[7:0];
                    `SCRX_OFF_C1: c1 <= w_data[7:0];
                    `SCRX_OFF_C2: c2 <= w_data[7:0];
                    `SCRX_OFF_S2: s2c <= {1'b0, 1'b0, 1'b0, w_data[4:1], 1'b0};
                    `SCRX_OFF_C3: c3c <= {2'b00, w_data[5:0]};
                    `SCRX_OFF_EN: men <= w_data[7:0];
                    default: men <= men;
                endcase
                if (aw_addr == `SCRX_OFF_S2 && w_data[6]) begin
                    f_edge <= 1'b0;
                end
            end
            if (ab_fire) begin
                bdh <= {bdh[7:5], ab_cnt[19:15]};
                bdl <= ab_cnt[14:7];
            end
            if (men[0] && bdh[`SCRX_BDH_EDGE] && !rx_in && flags_ok) begin
                f_edge <= 1'b1;
            end
            c2[`SCRX_C2_SLEEP] <= (wr_c2 ? w_data[`SCRX_C2_SLEEP] : c2[`SCRX_C2_SLEEP]) && !(idle_done && sleep
                && !c1[`SCRX_C1_WAKE]) && !wake_addr;
        end
    end

    // combinational wake keeps working without the baud clock
    assign rx_wake_irq = men[0] && bdh[`SCRX_BDH_EDGE] && !rx_pin && !s2c[`SCRX_S2_INV];
    assign irq = (f_tdre && c2[`SCRX_C2_TIE]) || (f_tc && c2[`SCRX_C2_TCIE]) || (f_rdrf && c2[`SCRX_C2_RIE])
        || (f_idle && c2[`SCRX_C2_ILIE]) || (f_edge && bdh[`SCRX_BDH_EDGE]);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `SCRX_OFF_BDH: s_axi_rdata <= {24'h0000_00, bdh};
                `SCRX_OFF_BDL: s_axi_rdata <= {24'h0000_00, bdl};
                `SCRX_OFF_C1: s_axi_rdata <= {24'h0000_00, c1};
                `SCRX_OFF_C2: s_axi_rdata <= {24'h0000_00, c2};
                `SCRX_OFF_S1: s_axi_rdata <= {24'h0000_00, f_tdre, f_tc, f_rdrf, f_idle, f_or, f_nf, f_fe, f_pf};
                `SCRX_OFF_S2: s_axi_rdata <= {24'h0000_00, 1'b0, f_edge, 1'b0, s2c[4:1], rs != RS_IDLE};
                `SCRX_OFF_C3: s_axi_rdata <= {24'h0000_00, rx_bit8, 1'b0, c3c[5:0]};
                `SCRX_OFF_D: s_axi_rdata <= {24'h0000_00, rx_data};
                `SCRX_OFF_EN: s_axi_rdata <= {24'h0000_00, men};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // scrx_uart
`default_nettype wire

// ### scrx_uart_props.sv
/* checker for the serial port block, watching its top-level pins.
   assumes writes offer address and data together; keeps a shadow of written registers. */
`timescale 1ns/10ps
`default_nettype none
module scrx_uart_chk (
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_bvalid, rx_pin, tx_pin_out, tx_pin_oe, irq, rx_wake_irq
);
    logic [7:0] sh [0:15];
    logic [1:0] age;
    wire st = age == 2'h3;
    wire sw = sh[2][7] && sh[2][5];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // shadow leads the register by one cycle, so checks wait until it settles
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 16; i++) sh[i] <= 8'h00;
            age <= 2'h0;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
            sh[s_axi_awaddr[5:2]] <= s_axi_wdata[7:0];
            age <= 2'h0;
        end else if (!st) begin
            age <= age + 2'h1;
        end
    end
    property p_rst_quiet; disable iff (1'b0) !aresetn |=> !rx_wake_irq && !irq; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("request active after reset");
    property p_rst_hold; $rose(aresetn) |-> !rx_wake_irq [*2]; endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("wake request right after reset");
    property p_wake_eq; st |-> rx_wake_irq == (sh[8][0] && sh[0][6] && !rx_pin && !sh[5][4]); endproperty
    a_wake_eq: assert property (p_wake_eq) else $error("wake request wrong");
    property p_wake_pin; rx_wake_irq |-> !rx_pin; endproperty
    a_wake_pin: assert property (p_wake_pin) else $error("wake with pin high");
    property p_sw_dir; st && sw |-> tx_pin_oe == sh[6][5]; endproperty
    a_sw_dir: assert property (p_sw_dir) else $error("single wire direction wrong");
    property p_oe_2wire; st && !sw |-> tx_pin_oe; endproperty
    a_oe_2wire: assert property (p_oe_2wire) else $error("tx pin released");
    property p_irq_gate; st && sh[3][7:4] == 4'h0 && !sh[0][6] |-> !irq; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq with enables off");
    property p_halt; st && {sh[0][4:0], sh[1]} == 13'h0000 |=> $stable(tx_pin_out); endproperty
    a_halt: assert property (p_halt) else $error("tx moved with divisor zero");
    cover property (rx_wake_irq);
    cover property (!tx_pin_oe);
    cover property (s_axi_bvalid);
endmodule // scrx_uart_chk
bind scrx_uart scrx_uart_chk i_scrx_uart_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_awaddr, .s_axi_wdata, .s_axi_bvalid, .rx_pin,
    .tx_pin_out, .tx_pin_oe, .irq, .rx_wake_irq);
`default_nettype wire

// ### scrx_node.sv
/* remote serial node driving frames onto the receive line.
   assumes a bit lasts BT clocks, sixteen baud ticks per bit. */
`timescale 1ns/10ps
`default_nettype none
module scrx_node #(parameter int BT = 64) (
    input wire logic aclk,
    output var logic line
);
    initial line = 1'b1;
    // gb picks a data bit for a one-tick spike: one vote flips, never the majority
    task automatic send(input logic [8:0] d, input int nb, input int gb);
        logic v;
        for (int i = 0; i < nb + 2; i++) begin
            v = (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i - 1];
            for (int k = 0; k < BT; k++) begin
                @(posedge aclk);
                line <= v ^ (gb >= 0 && i == gb + 1 && k / (BT / 16) == 8);
            end
        end
    endtask
endmodule // scrx_node
`default_nettype wire

// ### scrx_uart_tb.sv
/* self-checking bench for the serial port block.
   assumes the node model and bound checker are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
module scrx_uart_tb;
    localparam int DIV = 4;
    logic aclk = 1'b0, aresetn = 1'b0, hold_low = 1'b0, line, p;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, x;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_pin_out, tx_pin_oe, irq, rx_wake_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] d, s;
    int errors = 0, compares = 0;
    wire rx_pin = line && !hold_low;
    always #5 aclk = ~aclk;
    scrx_node #(.BT(16 * DIV)) i_scrx_node (.aclk, .line);
    scrx_uart i_scrx_uart (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rx_pin, .tx_pin_in(line), .tx_pin_out, .tx_pin_oe, .irq, .rx_wake_irq);
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic wrap_up;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // ready is sampled at the falling edge so the rising-edge update never races it
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        logic aw, w, b;
        @(posedge aclk);
        aw = 1'b1; w = 1'b1; b = 1'b0;
        s_axi_awaddr <= a; s_axi_wdata <= {24'h00_0000, v};
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        for (int n = 0; n < 100 && !b; n++) begin
            @(negedge aclk);
            aw = aw && !s_axi_awready; w = w && !s_axi_wready; b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            s_axi_awvalid <= aw; s_axi_wvalid <= w; s_axi_bready <= !b;
        end
        if (!b) begin errors++; wrap_up; end
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        logic ar, g;
        @(posedge aclk);
        ar = 1'b1; g = 1'b0; v = 8'h00;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        for (int n = 0; n < 100 && !g; n++) begin
            @(negedge aclk);
            ar = ar && !s_axi_arready; g = s_axi_rvalid; v = s_axi_rdata[7:0]; r = s_axi_rresp;
            @(posedge aclk);
            s_axi_arvalid <= ar; s_axi_rready <= !g;
        end
        if (!g) begin errors++; wrap_up; end
    endtask
    task automatic rxchk(input logic [8:0] f, input int nb, input int gb, input logic [7:0] m, input logic [7:0] e);
        i_scrx_node.send(f, nb, gb);
        rd(6'h10, s);
        chk(s & m, e);
    endtask
    initial begin
        x = 32'h0000_6f2c;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 10; i++) begin
            rd(6'(4 * i), d);
            chk(i < 9 ? {r, d} : {8'h00, r}, i < 9 ? 10'h000 : 10'h002);
        end
        wr(6'h04, 8'(DIV));
        wr(6'h20, 8'h01);
        chk(r, 2'b00);
        wr(6'h0c, 8'h04);
        for (int i = 0; i < 8; i++) begin
            x = lfsr(x);
            wr(6'h08, {7'h01, i[0]});
            p = ^x[6:0] ^ i[0] ^ i[1];
            rxchk({1'b0, p, x[6:0]}, 8, -1, 8'h25, {2'b00, 1'b1, 4'h0, i[1]});
            rd(6'h1c, d);
            chk(d, {p, x[6:0]});
        end
        wr(6'h08, 8'h00);
        rxchk(9'h000, 8, 3, 8'h25, 8'h24);
        rd(6'h1c, d);
        chk(d, 8'h00);
        wr(6'h08, 8'h10);
        i_scrx_node.send(9'h1a5, 9, -1);
        rd(6'h18, d);
        chk(d[7], 1'b1);
        rd(6'h1c, d);
        chk(d, 8'ha5);
        wr(6'h08, 8'h08);
        wr(6'h0c, 8'h06);
        rxchk(9'h012, 8, -1, 8'h20, 8'h00);
        rxchk(9'h092, 8, -1, 8'h20, 8'h20);
        rd(6'h0c, d);
        chk(d[1], 1'b0);
        rd(6'h1c, d);
        chk(d, 8'h92);
        wr(6'h00, 8'h40);
        hold_low <= 1'b1;
        @(negedge aclk);
        chk(rx_wake_irq, 1'b1);
        @(posedge aclk);
        hold_low <= 1'b0;
        wr(6'h08, 8'ha0);
        chk(tx_pin_oe, 1'b0);
        chk(irq, 1'b1);
        wr(6'h18, 8'h20);
        chk(tx_pin_oe, 1'b1);
        wr(6'h08, 8'h80);
        wr(6'h0c, 8'h0c);
        wr(6'h1c, 8'h3c);
        s = 8'h00;
        for (int n = 0; n < 600 && !s[5]; n++) rd(6'h10, s);
        chk(s[5], 1'b1);
        rd(6'h1c, d);
        chk(d, 8'h3c);
        wrap_up;
    end
endmodule // scrx_uart_tb
`default_nettype wire
